//--- asg_params.svh
`ifndef ASG_PARAMS_SVH
`define ASG_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses on the apb side)
`define ASG_OFF_WAIT_CTL   12'h000
`define ASG_OFF_SD_CTL     12'h004

// ==========================================================
// chip select 0 wait control fields
`define ASG_BW_MSB         17
`define ASG_BW_LSB         16
`define ASG_FW_MSB         10
`define ASG_FW_LSB         7
`define ASG_WM_BIT         6

// ==========================================================
// sdram control fields
`define ASG_ROW_MSB        20
`define ASG_ROW_LSB        19
`define ASG_COL_MSB        17
`define ASG_COL_LSB        16

// ==========================================================
// reset values
`define ASG_FW_RESET       4'ha
`define ASG_WM_RESET       1'h0
`define ASG_BW_RESET       2'h0
`define ASG_SD_RESET       32'h0000_0000

// ==========================================================
// width bases of the geometry codes
`define ASG_ROW_BASE       4'hb
`define ASG_COL_BASE       4'h8

`endif

//--- asg_pkg.sv
`default_nettype none

// ==========================================================
// shared types
package asg_pkg;

  // rom access sequencer
  typedef enum logic [1:0] {
    ASG_ROM_IDLE,
    ASG_ROM_FIRST,
    ASG_ROM_BURST
  } asg_rom_state_t;

  // sdram command sequencer
  typedef enum logic [1:0] {
    ASG_SD_IDLE,
    ASG_SD_ACT,
    ASG_SD_RW
  } asg_sd_state_t;

endpackage

`default_nettype wire

//--- asg_wait_counter.sv
`default_nettype none

// ==========================================================
// down counter for inserted wait cycles
module asg_wait_counter #(
  parameter int CNT_W = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clr,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  zero
);

  // a one-bit counter would need a zero-width replication
  if (CNT_W < 2) begin : g_chk_w
    $error("wait counter too narrow");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // clear wins, then load, otherwise count down and park at zero
  assign cnt_d = clr  ? '0 :
                 load ? load_val :
                 (cnt_q != '0) ? cnt_q - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q;
  assign zero  = (cnt_q == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

//--- asg_addr_split.sv
`default_nettype none

// ==========================================================
// splits a flat area 2 address into row and column parts
module asg_addr_split #(
  parameter int ADDR_W = 24
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              capture,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [3:0]        row_bits,
  input  wire logic [3:0]        col_bits,
  output logic      [12:0]       row_q,
  output logic      [9:0]        col_q
);

  // the widest row part reads bit 12 of the shifted address
  if (ADDR_W < 13) begin : g_chk_addr
    $error("address too narrow for the split");
  end

  logic [ADDR_W-1:0] shifted;
  logic [12:0]       row_d;
  logic [9:0]        col_d;

  // column is the low bits, row sits right above it
  assign shifted = addr >> col_bits;

  genvar i;
  for (i = 0; i < 13; i++) begin : g_row
    assign row_d[i] = (i < int'(row_bits)) ? shifted[i] : 1'b0;
  end
  for (i = 0; i < 10; i++) begin : g_col
    assign col_d[i] = (i < int'(col_bits)) ? addr[i] : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= '0;
      col_q <= '0;
    end else if (capture) begin
      row_q <= row_d;
      col_q <= col_d;
    end
  end

endmodule

`default_nettype wire

//--- asg_access_ctrl.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "asg_params.svh"
`default_nettype none

// ==========================================================
// Contract
// - first access waits 0..6, then 8,10,12,14,18,24 cycles by 4-bit code
// - first-wait field bits 10:7 resets to 1010, fourteen cycles
// - mask bit 6 resets 0; 0 honours external wait, 1 ignores it
// - external wait mask applies even with zero programmed wait
// - reserved bits read zero; software writes zero to them
// - sdram control clears to zero on power-on reset
// - sdram control kept through manual reset and standby
// - row width code bits 20:19: 11, 12 or 13 bits
// - column width code bits 17:16: 8, 9 or 10 bits
// - burst rom inserts 0..3 waits between later beats by 2-bit code
module asg_access_ctrl
  import asg_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int LEN_W  = 4
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // system state
  input  wire logic              manual_rst_n,
  input  wire logic              standby,
  // burst rom access
  input  wire logic              rom_req,
  input  wire logic [LEN_W-1:0]  rom_len,
  input  wire logic              ext_wait,
  output logic                   rom_busy,
  output logic                   rom_beat,
  output logic                   rom_last,
  // sdram area 2 access
  input  wire logic              sd_req,
  input  wire logic              sd_write,
  input  wire logic [ADDR_W-1:0] sd_addr,
  output logic                   sd_busy,
  output logic                   sd_act,
  output logic                   sd_rd,
  output logic                   sd_wr,
  output logic      [12:0]       sd_row,
  output logic      [9:0]        sd_col,
  // decoded geometry for the memory pins
  output logic      [3:0]        row_width,
  output logic      [3:0]        col_width
);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 23) begin : g_chk_addr
    $error("address too narrow for 13 row and 10 column bits");
  end
  if (LEN_W < 1 || LEN_W > 8) begin : g_chk_len
    $error("burst length width out of range");
  end

  // ==========================================================
  // register state
  logic [3:0]     fw_q;
  logic [3:0]     fw_d;
  logic           wm_q;
  logic           wm_d;
  logic [1:0]     bw_q;
  logic [1:0]     bw_d;
  logic [1:0]     row_q;
  logic [1:0]     row_d;
  logic [1:0]     col_q;
  logic [1:0]     col_d;
  logic [31:0]    prdata_q;
  logic [31:0]    prdata_d;

  // ==========================================================
  // apb decode
  wire            setup_ph   = psel & ~penable;
  wire            access_ph  = psel & penable;
  wire            hit_wait   = (paddr == `ASG_OFF_WAIT_CTL);
  wire            hit_sd     = (paddr == `ASG_OFF_SD_CTL);
  wire            hit_any    = hit_wait | hit_sd;
  wire            wr_wait    = access_ph & pwrite & hit_wait;
  wire            wr_sd      = access_ph & pwrite & hit_sd;

  // zero-wait slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata  = prdata_q;

  // ==========================================================
  // read images, reserved bits forced to zero
  logic [31:0]    wait_img;
  logic [31:0]    sd_img;

  // wait register as software sees it
  always_comb begin
    wait_img = 32'h0000_0000;
    wait_img[`ASG_BW_MSB:`ASG_BW_LSB] = bw_q;
    wait_img[`ASG_FW_MSB:`ASG_FW_LSB] = fw_q;
    wait_img[`ASG_WM_BIT] = wm_q;
  end

  // sdram register as software sees it
  always_comb begin
    sd_img = 32'h0000_0000;
    sd_img[`ASG_ROW_MSB:`ASG_ROW_LSB] = row_q;
    sd_img[`ASG_COL_MSB:`ASG_COL_LSB] = col_q;
  end

  // read data is prepared in setup so it stands for the whole access
  assign prdata_d = !(setup_ph & ~pwrite) ? prdata_q :
                    hit_wait ? wait_img :
                    hit_sd   ? sd_img   : 32'h0000_0000;

  // read data register; writes and idle cycles leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // wait control register; manual reset reinitialises it
  assign fw_d = !manual_rst_n ? `ASG_FW_RESET :
                wr_wait ? pwdata[`ASG_FW_MSB:`ASG_FW_LSB] : fw_q;
  assign wm_d = !manual_rst_n ? `ASG_WM_RESET :
                wr_wait ? pwdata[`ASG_WM_BIT] : wm_q;
  assign bw_d = !manual_rst_n ? `ASG_BW_RESET :
                wr_wait ? pwdata[`ASG_BW_MSB:`ASG_BW_LSB] : bw_q;

  // power-on values here; the manual reset goes through the next-value
  // mux because it is synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_q <= `ASG_FW_RESET;
      wm_q <= `ASG_WM_RESET;
      bw_q <= `ASG_BW_RESET;
    end else begin
      fw_q <= fw_d;
      wm_q <= wm_d;
      bw_q <= bw_d;
    end
  end

  // ==========================================================
  // sdram control; only power-on reset clears it
  assign row_d = wr_sd ? pwdata[`ASG_ROW_MSB:`ASG_ROW_LSB] : row_q;
  assign col_d = wr_sd ? pwdata[`ASG_COL_MSB:`ASG_COL_LSB] : col_q;

  // only presetn clears it; manual reset and standby must keep the
  // geometry so that sdram already set up stays addressable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 2'(`ASG_SD_RESET >> `ASG_ROW_LSB);
      col_q <= 2'(`ASG_SD_RESET >> `ASG_COL_LSB);
    end else begin
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  // ==========================================================
  // geometry decode; the prohibited code falls back to the widest
  assign row_width = (row_q == 2'h3) ? `ASG_ROW_BASE + 4'h2 :
                     `ASG_ROW_BASE + {2'h0, row_q};
  assign col_width = (col_q == 2'h3) ? `ASG_COL_BASE + 4'h2 :
                     `ASG_COL_BASE + {2'h0, col_q};

  // ==========================================================
  // first access wait decode; the prohibited codes map to the longest
  // wait, so a mis-set register slows an access rather than breaking it
  function automatic logic [4:0] first_waits(input logic [3:0] code);
    logic [4:0] n;
    n = 5'h18;
    case (code)
      4'h7:    n = 5'h08;
      4'h8:    n = 5'h0a;
      4'h9:    n = 5'h0c;
      4'ha:    n = 5'h0e;
      4'hb:    n = 5'h12;
      4'hc:    n = 5'h18;
      4'hd,
      4'he,
      4'hf:    n = 5'h18; // prohibited codes; longest wait is the safe side
      default: n = {1'b0, code};
    endcase
    return n;
  endfunction

  wire [4:0]      fw_cycles  = first_waits(fw_q);
  wire [4:0]      bw_cycles  = {3'h0, bw_q};

  // ==========================================================
  // burst rom sequencer
  asg_rom_state_t rom_st_q;
  asg_rom_state_t rom_st_d;
  logic [LEN_W-1:0] left_q;
  logic [LEN_W-1:0] left_d;
  logic             cnt_load;
  logic [4:0]       cnt_val;
  logic             cnt_zero;

  // the mask bit gates external wait regardless of programmed count
  wire            ext_hold   = ext_wait & ~wm_q;
  wire            rom_start  = (rom_st_q == ASG_ROM_IDLE) & rom_req & ~standby;
  wire            first_done = (rom_st_q == ASG_ROM_FIRST) & cnt_zero & ~ext_hold;
  wire            burst_done = (rom_st_q == ASG_ROM_BURST) & cnt_zero;
  wire            beat_now   = first_done | burst_done;
  wire            more_beats = (left_q != '0);

  assign rom_beat = beat_now;
  assign rom_last = beat_now & ~more_beats;
  assign rom_busy = (rom_st_q != ASG_ROM_IDLE);

  // counter loads the first wait on start, burst wait after each beat but the last
  assign cnt_load = rom_start | (beat_now & more_beats);
  assign cnt_val  = rom_start ? fw_cycles : bw_cycles;

  asg_wait_counter #(
    .CNT_W    (5)
  ) u_wait_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (~manual_rst_n),
    .load     (cnt_load),
    .load_val (cnt_val),
    .zero     (cnt_zero)
  );

  // next state of the rom sequencer
  always_comb begin
    rom_st_d = rom_st_q;
    left_d   = left_q;
    case (rom_st_q)
      ASG_ROM_IDLE: begin
        if (rom_start) begin
          rom_st_d = ASG_ROM_FIRST;
          left_d   = rom_len;
        end
      end
      ASG_ROM_FIRST,
      ASG_ROM_BURST: begin
        if (beat_now) begin
          if (more_beats) begin
            rom_st_d = ASG_ROM_BURST;
            left_d   = left_q - {{(LEN_W-1){1'b0}}, 1'b1};
          end else begin
            rom_st_d = ASG_ROM_IDLE;
          end
        end
      end
      default: rom_st_d = ASG_ROM_IDLE;
    endcase
    if (!manual_rst_n) begin
      rom_st_d = ASG_ROM_IDLE;
      left_d   = '0;
    end
  end

  // rom sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_st_q <= ASG_ROM_IDLE;
      left_q   <= '0;
    end else begin
      rom_st_q <= rom_st_d;
      left_q   <= left_d;
    end
  end

  // ==========================================================
  // sdram command sequencer: activate with row, then read or write
  asg_sd_state_t  sd_st_q;
  asg_sd_state_t  sd_st_d;
  logic           sd_wr_q;
  logic           sd_wr_d;

  wire            sd_start = (sd_st_q == ASG_SD_IDLE) & sd_req & ~standby;

  assign sd_busy = (sd_st_q != ASG_SD_IDLE);
  assign sd_act  = (sd_st_q == ASG_SD_ACT);
  assign sd_rd   = (sd_st_q == ASG_SD_RW) & ~sd_wr_q;
  assign sd_wr   = (sd_st_q == ASG_SD_RW) & sd_wr_q;
  assign sd_wr_d = sd_start ? sd_write : sd_wr_q;

  // widths are sampled at capture, so a later register write
  // cannot tear an access already under way
  asg_addr_split #(
    .ADDR_W   (ADDR_W)
  ) u_split (
    .pclk     (pclk),
    .presetn  (presetn),
    .capture  (sd_start),
    .addr     (sd_addr),
    .row_bits (row_width),
    .col_bits (col_width),
    .row_q    (sd_row),
    .col_q    (sd_col)
  );

  // next state of the sdram sequencer
  always_comb begin
    sd_st_d = sd_st_q;
    case (sd_st_q)
      ASG_SD_IDLE: begin
        if (sd_start) begin
          sd_st_d = ASG_SD_ACT;
        end
      end
      ASG_SD_ACT:  sd_st_d = ASG_SD_RW;
      ASG_SD_RW:   sd_st_d = ASG_SD_IDLE;
      default:     sd_st_d = ASG_SD_IDLE;
    endcase
    if (!manual_rst_n) begin
      sd_st_d = ASG_SD_IDLE;
    end
  end

  // sdram sequencer state; the direction is latched at the start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_st_q <= ASG_SD_IDLE;
      sd_wr_q <= 1'b0;
    end else begin
      sd_st_q <= sd_st_d;
      sd_wr_q <= sd_wr_d;
    end
  end

endmodule

`default_nettype wire

//--- asg_mem_model.sv
`default_nettype none

// ==========================================================
// far-side rom: holds its wait line up for a set number of
// cycles at the start of every rom access
module asg_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rom_busy,
  input  wire logic [3:0] stall,
  output logic            ext_wait
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] left_q;
  logic [3:0] left_d;

  // reload while idle so each access sees the full stall
  assign left_d   = !rom_busy ? stall : ((left_q != 4'h0) ? left_q - 4'h1 : 4'h0);
  assign ext_wait = rom_busy && (left_q != 4'h0); // raised only while selected

  // stall counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 4'h0;
    end else begin
      left_q <= left_d;
    end
  end
endmodule

`default_nettype wire

//--- asg_props.sv
`default_nettype none

// ==========================================================
// port checker for the access controller
module asg_props #(
  parameter int ADDR_W = 24
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       prdata,
  input  wire logic              pslverr,
  input  wire logic              manual_rst_n,
  input  wire logic              standby,
  input  wire logic              rom_busy,
  input  wire logic              rom_beat,
  input  wire logic              rom_last,
  input  wire logic [ADDR_W-1:0] sd_addr,
  input  wire logic              sd_busy,
  input  wire logic              sd_act,
  input  wire logic              sd_rd,
  input  wire logic              sd_wr,
  input  wire logic [12:0]       sd_row,
  input  wire logic [9:0]        sd_col,
  input  wire logic [3:0]        row_width,
  input  wire logic [3:0]        col_width
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decode of refused accesses and of quiet register phases
  wire logic unmapped = psel && penable && (paddr != 12'h000) && (paddr != 12'h004);
  wire logic quiet    = (!manual_rst_n || standby) && !psel;

  // sdram walk: one column command, then back to idle
  sequence sd_cmd_s;
    (sd_rd ^ sd_wr) && !sd_act;
  endsequence
  sequence sd_idle_s;
    !sd_busy && !sd_rd && !sd_wr;
  endsequence

  a_unmapped_err: assert property (unmapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_last_ends: assert property (rom_last |-> rom_beat ##1 !rom_busy)
    else $error("rom access does not end after last beat");
  a_sd_walk: assert property (sd_act |-> sd_busy ##1 sd_cmd_s ##1 sd_idle_s)
    else $error("sdram command order wrong");
  a_col_split: assert property (
      sd_act |-> sd_col == 10'($past(sd_addr) & ~({ADDR_W{1'b1}} << col_width)))
    else $error("column part wrong");
  a_row_split: assert property (
      sd_act |-> sd_row == 13'(($past(sd_addr) >> col_width) & ~({ADDR_W{1'b1}} << row_width)))
    else $error("row part wrong");
  a_reset_geom: assert property ($rose(presetn) |-> row_width == 4'hb && col_width == 4'h8)
    else $error("geometry not cleared by power-on reset");
  a_keep_geom: assert property (quiet |=> $stable(row_width) && $stable(col_width))
    else $error("geometry lost in manual reset or standby");
  a_width_legal: assert property (
      row_width inside {4'hb, 4'hc, 4'hd} && col_width inside {4'h8, 4'h9, 4'ha})
    else $error("decoded width out of range");
  a_beat_busy: assert property (rom_beat |-> rom_busy)
    else $error("rom beat outside an access");
endmodule

bind asg_access_ctrl asg_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .manual_rst_n, .standby,
  .rom_busy, .rom_beat, .rom_last, .sd_addr, .sd_busy, .sd_act, .sd_rd, .sd_wr, .sd_row,
  .sd_col, .row_width, .col_width
);

`default_nettype wire

//--- access_wait_sdram_geometry_test.sv
`default_nettype none

module access_wait_sdram_geometry_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus and observed signals
  logic        pclk = 1'b0, presetn = 1'b0, manual_rst_n = 1'b1, standby = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rom_req = 1'b0;
  logic        sd_req = 1'b0, sd_write = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [3:0]  rom_len = 4'h0, stall = 4'h3, row_width, col_width;
  logic [23:0] sd_addr = 24'h00_0000;
  logic        pready, pslverr, ext_wait, rom_busy, rom_beat, rom_last;
  logic        sd_busy, sd_act, sd_rd, sd_wr;
  logic [12:0] sd_row;
  logic [9:0]  sd_col;
  int          num_errors = 0, checked = 0, n;
  localparam int FirstWait[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

  // ==========================================================
  // clock, block and far-side model
  always #5 pclk = ~pclk;

  asg_access_ctrl #(.ADDR_W(24), .LEN_W(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .manual_rst_n, .standby, .rom_req, .rom_len, .ext_wait, .rom_busy,
    .rom_beat, .rom_last, .sd_req, .sd_write, .sd_addr, .sd_busy, .sd_act, .sd_rd,
    .sd_wr, .sd_row, .sd_col, .row_width, .col_width
  );
  asg_mem_model u_mem (.pclk, .presetn, .rom_busy, .stall, .ext_wait);

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, r);
  endtask

  // n counts cycles from the take edge to the last beat
  task automatic rom_run(input logic [3:0] len);
    @(posedge pclk);
    rom_req <= 1'b1;
    rom_len <= len;
    @(posedge pclk);
    rom_req <= 1'b0;
    #1;
    n = 0;
    while (rom_last !== 1'b1 && n < 100) begin
      @(posedge pclk);
      #1;
      n++;
    end
    @(posedge pclk);
  endtask

  task automatic sd_run(input logic w, input logic [23:0] a, input int rb, input int cb);
    @(posedge pclk);
    sd_req <= 1'b1;
    sd_write <= w;
    sd_addr <= a;
    @(posedge pclk);
    sd_req <= 1'b0;
    #1;
    chk("sd_act", 32'h0000_0001, 32'(sd_act));
    chk("sd_row", 32'((a >> cb) & ~(24'hff_ffff << rb)), 32'(sd_row));
    chk("sd_col", 32'(a & ~(24'hff_ffff << cb)), 32'(sd_col));
    @(posedge pclk);
    #1;
    chk("sd_cmd", 32'({!w, w}), 32'({sd_rd, sd_wr}));
    @(posedge pclk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0000_0500);
    rd(12'h004, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(e));
    // every legal first-wait code with the wait line masked
    for (int c = 0; c < 13; c++) begin
      apb(1'b1, 12'h000, 32'(c << 7) | 32'h0000_0040);
      rom_run(4'h0);
      chk("first wait", 32'(FirstWait[c]), 32'(n));
    end
    rd(12'h000, 32'h0000_0640);
    // mask clear: the wait line stretches even a zero-wait access
    apb(1'b1, 12'h000, 32'h0000_0000);
    rom_run(4'h0);
    chk("stretched", 32'h0000_0003, 32'(n));
    // three beats, three waits between later beats
    apb(1'b1, 12'h000, 32'h0003_00c0);
    rom_run(4'h2);
    chk("burst span", 32'h0000_0009, 32'(n));
    // every legal geometry code
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, 12'h004, 32'(g << 19) | 32'(g << 16));
      #1; // the write lands at the edge that ends the task
      chk("row_width", 32'(11 + g), 32'(row_width));
      chk("col_width", 32'(8 + g), 32'(col_width));
      sd_run(g[0], 24'h12_3456 + 24'(g), 11 + g, 8 + g);
    end
    // manual reset then standby; rom start blocked, geometry kept
    manual_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    manual_rst_n <= 1'b1;
    standby <= 1'b1;
    rom_req <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("rom_busy", 32'h0000_0000, 32'(rom_busy));
    @(posedge pclk);
    rom_req <= 1'b0;
    rd(12'h004, 32'h0012_0000);
    rd(12'h000, 32'h0000_0500);
    standby <= 1'b0;
    // second power-on reset clears the sdram control register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 32'h0000_0000);
    close_out();
  end

  // hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #100_000;
    num_errors++;
    close_out();
  end
endmodule

`default_nettype wire
